// *** test/srwd_checker.sv ***
`timescale 1ns/1ps

module srwd_checker #(
  parameter int unsigned HOLD_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic pin_reset_i,
  input wire logic low_voltage_detect_i,
  input wire logic illegal_opcode_i,
  input wire logic illegal_address_i,
  input wire logic debug_force_reset_i,
  input wire logic sys_reset_o,
  input wire logic [15:0] stack_ptr_init_o,
  input wire logic imask_set_o,
  input wire logic periph_disable_o,
  input wire logic pins_hiz_o,
  input wire logic pullup_enable_o
);
  logic req;
  logic [7:0] hi_cnt;
  logic [7:0] next_hi_cnt;

  // New request outside a reset pulse
  assign req = wb_cyc_i & wb_stb_i & !wb_ack_o & !sys_reset_o;

  // Length of the current reset pulse
  always_comb begin
    next_hi_cnt = sys_reset_o ? hi_cnt + 8'h01 : 8'h00;
  end

  // Reset preloads, so the first pulse never looks short
  always_ff @(posedge clk_i) begin
    hi_cnt <= rst_i ? 8'(HOLD_CYC) : next_hi_cnt;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_sp;
    stack_ptr_init_o == 16'h00ff;
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer init wrong");

  property p_mask;
    imask_set_o == sys_reset_o;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt mask not tied to reset");

  property p_pins;
    pins_hiz_o == sys_reset_o && periph_disable_o == sys_reset_o && !pullup_enable_o;
  endproperty
  a_pins: assert property (p_pins) else $error("pins or peripherals wrong in reset");

  property p_ack;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not a single pulse");

  property p_bad;
    req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[1:0] == 2'h3
      && !(wb_dat_i[15:0] inside {16'h0055, 16'h00aa}) |=> sys_reset_o;
  endproperty
  a_bad: assert property (p_bad) else $error("bad service value gave no reset");

  property p_cause;
    pin_reset_i || low_voltage_detect_i || illegal_opcode_i || illegal_address_i
      |=> sys_reset_o;
  endproperty
  a_cause: assert property (p_cause) else $error("reset cause ignored");

  property p_dbg;
    debug_force_reset_i |=> sys_reset_o;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug reset ignored");

  property p_unmap;
    req && (wb_adr_i[1:0] != 2'h0 || wb_adr_i > 8'h0c) |=> sys_reset_o;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access gave no reset");

  property p_hold;
    $fell(sys_reset_o) |-> hi_cnt >= 8'(HOLD_CYC);
  endproperty
  a_hold: assert property (p_hold) else $error("system reset pulse too short");
endmodule

// *** test/srwd_tb_top.sv ***
`timescale 1ns/1ps

module srwd_tb_top;
  typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} srwd_row_t;
  logic clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
  logic tick_1khz_i = '0, bdm_active_i = '0, stop_mode_i = '0, debug_force_reset_i = '0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf, cause = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, ack_dat, rd, rd2;
  logic wb_ack_o, sys_reset_o, imask_set_o, periph_disable_o, pins_hiz_o, pullup_enable_o;
  logic ack_s, rst_s;
  logic [15:0] stack_ptr_init_o;
  wire pin_reset_i = cause[3];
  wire low_voltage_detect_i = cause[2];
  wire illegal_opcode_i = cause[1];
  wire illegal_address_i = cause[0];
  logic [7:0] st_exp [4] = '{8'h40, 8'h02, 8'h10, 8'h08};
  int n_mismatch = 0, samples_checked = 0, cyc_n = 0;
  srwd_row_t tbl [15] = '{
    '{1'h0, 8'h00, 32'h0, 32'h80}, '{1'h0, 8'h04, 32'h0, 32'h03},
    '{1'h0, 8'h08, 32'h0, 32'h01}, '{1'h1, 8'h0c, 32'h5, 32'h0},
    '{1'h0, 8'h0c, 32'h0, 32'h0}, '{1'h1, 8'h04, 32'h3, 32'h0},
    '{1'h0, 8'h04, 32'h0, 32'h103}, '{1'h1, 8'h04, 32'h1, 32'h0},
    '{1'h0, 8'h04, 32'h0, 32'h103}, '{1'h1, 8'h08, 32'h0, 32'h0},
    '{1'h0, 8'h08, 32'h0, 32'h100}, '{1'h1, 8'h08, 32'h3, 32'h0},
    '{1'h0, 8'h08, 32'h0, 32'h100}, '{1'h1, 8'h00, 32'h55, 32'h0},
    '{1'h1, 8'h00, 32'haa, 32'h0}};

  // Default reset pulse length and middle bus timeout are kept as built
  srwd_top #(.BUS_TO1(16), .BUS_TO3(64), .LPO_TO1(8), .LPO_TO2(16),
    .LPO_TO3(32)) i_dut (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .tick_1khz_i, .bdm_active_i, .stop_mode_i, .pin_reset_i, .low_voltage_detect_i,
    .illegal_opcode_i, .illegal_address_i, .debug_force_reset_i, .sys_reset_o,
    .stack_ptr_init_o, .imask_set_o, .periph_disable_o, .pins_hiz_o, .pullup_enable_o);

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // Mid-cycle copies equal what the next rising edge samples
  always @(negedge clk_i) begin
    ack_s = wb_ack_o;
    ack_dat = wb_dat_o;
    rst_s = sys_reset_o;
  end

  // Run needs about 600 cycles; ceiling leaves ample margin
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_s !== 1'h1 && n < 40);
    if (n == 40) chk("ack", 32'h1, 32'h0);
    rd = ack_dat;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask

  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (rst_s !== v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("sys_reset", {31'h0, v}, {31'h0, rst_s});
  endtask

  // Wait out a reset pulse, then read the cause
  task automatic status_is(input logic [31:0] e);
    wait_lvl(1'h1);
    wait_lvl(1'h0);
    wb(1'h0, 8'h00, 32'h0);
    chk("status", e, rd);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(negedge clk_i);
    chk("sp", 32'h00ff, {16'h0, stack_ptr_init_o});
    wait_lvl(1'h0);
    foreach (tbl[i]) begin
      wb(tbl[i].we, tbl[i].a, tbl[i].d);
      if (!tbl[i].we) chk("table", tbl[i].e, rd);
    end
    wb(1'h0, 8'h0c, 32'h0);
    chk("restart", 32'h1, {31'h0, rd < 32'h8});
    status_is(32'h20);
    wb(1'h0, 8'h04, 32'h0);
    chk("defaults", 32'h3, rd);
    wb(1'h1, 8'h08, 32'h3);
    wb(1'h1, 8'h00, 32'h55);
    wb(1'h1, 8'h00, 32'haa);
    repeat (3) @(posedge clk_i);
    chk("no_window", 32'h0, {31'h0, rst_s});
    repeat (3) begin
      tick_1khz_i <= 1'h1;
      @(posedge clk_i);
      tick_1khz_i <= 1'h0;
      @(posedge clk_i);
    end
    wb(1'h0, 8'h0c, 32'h0);
    chk("ticks", 32'h3, rd);
    bdm_active_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    bdm_active_i <= 1'h0;
    wb(1'h0, 8'h0c, 32'h0);
    chk("debug_clear", 32'h0, rd);
    wb(1'h1, 8'h00, 32'h12);
    status_is(32'h20);
    wb(1'h1, 8'h04, 32'h1);
    wb(1'h1, 8'h08, 32'h2);
    wb(1'h1, 8'h00, 32'h55);
    status_is(32'h20);
    // No lanes selected: options one locks with its default select
    wb_sel_i <= 4'h0;
    wb(1'h1, 8'h04, 32'h1);
    wb_sel_i <= 4'hf;
    wb(1'h0, 8'h04, 32'h0);
    chk("sel_lock", 32'h103, rd);
    // Bus clock, third timeout (64 counts), windowed: service late in the period
    wb(1'h1, 8'h08, 32'h2);
    repeat (50) @(posedge clk_i);
    wb(1'h1, 8'h00, 32'h55);
    wb(1'h1, 8'h00, 32'haa);
    repeat (3) @(posedge clk_i);
    chk("in_window", 32'h0, {31'h0, rst_s});
    stop_mode_i <= 1'h1;
    wb(1'h0, 8'h0c, 32'h0);
    rd2 = rd;
    wb(1'h0, 8'h0c, 32'h0);
    chk("stop_count", 32'h1, {31'h0, rd2 != 32'h0});
    chk("stop_hold", rd2, rd);
    stop_mode_i <= 1'h0;
    wb(1'h0, 8'h0c, 32'h0);
    chk("resume", 32'h1, {31'h0, rd > rd2});
    for (int i = 0; i < 4; i++) begin
      cause <= 4'h8 >> i;
      @(posedge clk_i);
      cause <= 4'h0;
      status_is({24'h0, st_exp[i]});
    end
    debug_force_reset_i <= 1'h1;
    @(posedge clk_i);
    debug_force_reset_i <= 1'h0;
    status_is(32'h0);
    wb(1'h0, 8'h10, 32'h0);
    status_is(32'h08);
    wb(1'h1, 8'h04, 32'h0);
    wb(1'h1, 8'h08, 32'h0);
    repeat (100) @(posedge clk_i);
    chk("disabled", 32'h0, {31'h0, rst_s});
    rst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    wait_lvl(1'h0);
    wb(1'h0, 8'h00, 32'h0);
    chk("por", 32'h80, rd);
    end_sim();
  end
endmodule

bind srwd_top srwd_checker #(.HOLD_CYC(HOLD_CYC)) i_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .pin_reset_i,
  .low_voltage_detect_i, .illegal_opcode_i, .illegal_address_i, .debug_force_reset_i,
  .sys_reset_o, .stack_ptr_init_o, .imask_set_o, .periph_disable_o, .pins_hiz_o,
  .pullup_enable_o);

// *** verilog/srwd_counter.sv ***
`timescale 1ns/1ps
`include "srwd_defs.svh"

module srwd_counter import srwd_pkg::*; #(
  parameter int CNT_W = 18,
  parameter int unsigned BUS_TO1 = `SRWD_BUS_TO1,
  parameter int unsigned BUS_TO2 = `SRWD_BUS_TO2,
  parameter int unsigned BUS_TO3 = `SRWD_BUS_TO3,
  parameter int unsigned LPO_TO1 = `SRWD_LPO_TO1,
  parameter int unsigned LPO_TO2 = `SRWD_LPO_TO2,
  parameter int unsigned LPO_TO3 = `SRWD_LPO_TO3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire srwd_cfg_t cfg_i,
  input wire logic tick_1khz_i,
  input wire logic halt_i,
  input wire logic clear_i,
  output logic [CNT_W-1:0] count_o,
  output logic expire_o,
  output logic in_window_o
);

  // Overflow count for a configuration, zero when off
  function automatic logic [CNT_W:0] limit_of(input srwd_cfg_t c);
    logic [31:0] v;
    v = 32'h0;
    unique case ({c.clk_sel, c.tsel})
      3'h1: v = BUS_TO1;
      3'h2: v = BUS_TO2;
      3'h3: v = BUS_TO3;
      3'h5: v = LPO_TO1;
      3'h6: v = LPO_TO2;
      3'h7: v = LPO_TO3;
      default: v = 32'h0;
    endcase
    return v[CNT_W:0];
  endfunction

  logic [CNT_W-1:0] next_count;
  logic [CNT_W:0] lim;
  logic step;
  logic at_end;

  assign lim = limit_of(cfg_i);
  assign step = (cfg_i.clk_sel == 1'b0) ? 1'b1 : tick_1khz_i;
  assign at_end = ({1'b0, count_o} == lim - {{CNT_W{1'b0}}, 1'b1});
  // overflow when the last count is passed
  assign expire_o = (lim != '0) && !clear_i && !halt_i && step && at_end;
  // last quarter of the selected period
  assign in_window_o = ({1'b0, count_o} >= lim - (lim >> 2));

  // Counter next value
  always_comb begin
    next_count = count_o;
    if (clear_i || lim == '0) begin
      // counter idle while timeout select is zero
      next_count = '0;
    end else if (halt_i) begin
      // bus clock holds; 1 kHz source clears and restarts
      next_count = cfg_i.clk_sel ? '0 : count_o;
    end else if (step) begin
      next_count = at_end ? '0 : count_o + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else begin
      count_o <= next_count;
    end
  end

endmodule

// *** verilog/srwd_defs.svh ***
`ifndef SRWD_DEFS_SVH
`define SRWD_DEFS_SVH

// Register byte offsets on the Wishbone port
`define SRWD_OFF_RESET_STATUS 8'h00
`define SRWD_OFF_OPTIONS_ONE 8'h04
`define SRWD_OFF_OPTIONS_TWO 8'h08
`define SRWD_OFF_WDOG_COUNT 8'h0c

// Reset status register bit positions
`define SRWD_RS_POR 7
`define SRWD_RS_PIN 6
`define SRWD_RS_WDOG 5
`define SRWD_RS_ILLEGAL_OPCODE_RESET 4
`define SRWD_RS_ILLEGAL_ADDRESS_RESET 3
`define SRWD_RS_LVD 1

// Options one: timeout select field, lock flag
`define SRWD_O1_TSEL_LSB 0
`define SRWD_O1_LOCK 8
// Options two: clock select, window enable, lock flag
`define SRWD_O2_CLKSEL 0
`define SRWD_O2_WINEN 1
`define SRWD_O2_LOCK 8

// Service sequence values
`define SRWD_SVC_FIRST 16'h0055
`define SRWD_SVC_SECOND 16'h00aa

// Reset defaults: 1 kHz source, longest timeout, no window
`define SRWD_TSEL_RESET 2'h3
`define SRWD_TSEL_OFF 2'h0
`define SRWD_CLKSEL_RESET 1'h1
`define SRWD_WINEN_RESET 1'h0

// Overflow counts per clock source and select code
`define SRWD_BUS_TO1 32'd8192
`define SRWD_BUS_TO2 32'd65536
`define SRWD_BUS_TO3 32'd262144
`define SRWD_LPO_TO1 32'd32
`define SRWD_LPO_TO2 32'd256
`define SRWD_LPO_TO3 32'd1024

// Stack pointer value forced during reset
`define SRWD_SP_RESET 16'h00ff

// System reset pulse length
`define SRWD_CLK_MHZ 200
`define SRWD_HOLD_NS 100
`define SRWD_HOLD_CYC ((`SRWD_HOLD_NS * `SRWD_CLK_MHZ + 999) / 1000)

`endif

// *** verilog/srwd_pkg.sv ***
package srwd_pkg;

  // Watchdog configuration as captured from the options registers
  typedef struct packed {
    logic clk_sel;
    logic win_en;
    logic [1:0] tsel;
  } srwd_cfg_t;

  // Reset causes recorded in the status register
  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic illegal_opcode_reset;
    logic illegal_address_reset;
    logic low_voltage_detect;
  } srwd_cause_t;

  typedef enum logic [0:0] {
    SRWD_SVC_IDLE = 1'b0,
    SRWD_SVC_ARMED = 1'b1
  } srwd_svc_t;

endpackage

// *** verilog/srwd_top.sv ***
// Behaviour
// - Watchdog enabled after every reset
// - Timeout select zero stops the watchdog
// - Service is 0x0055 then 0x00AA only
// - Service writes keep reset status bits
// - Second service value restarts the period
// - Timeout without service forces system reset
// - Other value to status address resets
// - Clock select picks bus or 1 kHz
// - Two-bit select: three timeouts or off
// - Defaults: 1 kHz source, 2^10 count
// - Windowed service only in last quarter
// - Early windowed service resets immediately
// - 1 kHz source ignores window enable
// - First options writes lock the configuration
// - Bus clock: counter holds in debug/stop
// - 1 kHz: counter clears in debug/stop
// - Status bit per cause, not debug reset
// - Unmapped access gives illegal address reset
// - Reset forces stack pointer, sets mask
// - Reset disables peripherals, pins plain inputs
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "srwd_defs.svh"

module srwd_top import srwd_pkg::*; #(
  parameter int ADR_W = 8,
  parameter int CNT_W = 18,
  parameter int unsigned HOLD_CYC = `SRWD_HOLD_CYC,
  parameter int unsigned BUS_TO1 = `SRWD_BUS_TO1,
  parameter int unsigned BUS_TO2 = `SRWD_BUS_TO2,
  parameter int unsigned BUS_TO3 = `SRWD_BUS_TO3,
  parameter int unsigned LPO_TO1 = `SRWD_LPO_TO1,
  parameter int unsigned LPO_TO2 = `SRWD_LPO_TO2,
  parameter int unsigned LPO_TO3 = `SRWD_LPO_TO3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tick_1khz_i,
  input wire logic bdm_active_i,
  input wire logic stop_mode_i,
  input wire logic pin_reset_i,
  input wire logic low_voltage_detect_i,
  input wire logic illegal_opcode_i,
  input wire logic illegal_address_i,
  input wire logic debug_force_reset_i,
  output logic sys_reset_o,
  output logic [15:0] stack_ptr_init_o,
  output logic imask_set_o,
  output logic periph_disable_o,
  output logic pins_hiz_o,
  output logic pullup_enable_o
);

  localparam logic [15:0] HOLD_LOAD = 16'(HOLD_CYC);

  // Full byte address decode shared by read and write paths
  function automatic logic is_reg(input logic [ADR_W-1:0] adr, input logic [7:0] off);
    return adr == ADR_W'(off);
  endfunction

  // Reset causes into the status register layout
  function automatic logic [7:0] status_word(input srwd_cause_t c);
    logic [7:0] w;
    w = 8'h00;
    w[`SRWD_RS_POR] = c.por;
    w[`SRWD_RS_PIN] = c.pin;
    w[`SRWD_RS_WDOG] = c.wdog;
    w[`SRWD_RS_ILLEGAL_OPCODE_RESET] = c.illegal_opcode_reset;
    w[`SRWD_RS_ILLEGAL_ADDRESS_RESET] = c.illegal_address_reset;
    w[`SRWD_RS_LVD] = c.low_voltage_detect;
    return w;
  endfunction

  // State
  srwd_cfg_t cfg;
  srwd_cfg_t next_cfg;
  logic lock_one;
  logic next_lock_one;
  logic lock_two;
  logic next_lock_two;
  srwd_svc_t svc;
  srwd_svc_t next_svc;
  srwd_cause_t status;
  srwd_cause_t next_status;
  logic [15:0] hold_cnt;
  logic [15:0] next_hold_cnt;
  logic [31:0] next_dat;
  logic next_ack;

  // Watchdog counter wires
  logic [CNT_W-1:0] wd_count;
  logic wd_expire;
  logic wd_in_window;
  logic wd_clear;
  logic wd_halt;

  // Bus decode
  logic req;
  logic wr;
  logic mapped;
  logic in_reset;
  logic [15:0] wval;
  logic win_bad;
  logic wd_on;
  srwd_cause_t cause;
  logic any_cause;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign in_reset = (hold_cnt != 16'h0);
  assign mapped = is_reg(wb_adr_i, `SRWD_OFF_RESET_STATUS) ||
                  is_reg(wb_adr_i, `SRWD_OFF_OPTIONS_ONE) ||
                  is_reg(wb_adr_i, `SRWD_OFF_OPTIONS_TWO) ||
                  is_reg(wb_adr_i, `SRWD_OFF_WDOG_COUNT);
  // Lanes not selected read as zero in the service value
  assign wval = wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wd_on = (cfg.tsel != `SRWD_TSEL_OFF);
  // window applies only with bus clock and window enabled
  // 1 kHz source always runs unwindowed
  assign win_bad = !cfg.clk_sel && cfg.win_en && wd_on && !wd_in_window;
  // bus clock halts in debug or stop
  assign wd_halt = bdm_active_i || stop_mode_i;

  srwd_counter #(
    .CNT_W(CNT_W),
    .BUS_TO1(BUS_TO1),
    .BUS_TO2(BUS_TO2),
    .BUS_TO3(BUS_TO3),
    .LPO_TO1(LPO_TO1),
    .LPO_TO2(LPO_TO2),
    .LPO_TO3(LPO_TO3)
  ) u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg_i(cfg),
    .tick_1khz_i(tick_1khz_i),
    .halt_i(wd_halt),
    .clear_i(wd_clear),
    .count_o(wd_count),
    .expire_o(wd_expire),
    .in_window_o(wd_in_window)
  );

  // Service sequence and reset cause collection
  always_comb begin
    next_svc = svc;
    wd_clear = in_reset;
    cause = '0;
    cause.pin = pin_reset_i;
    cause.low_voltage_detect = low_voltage_detect_i;
    cause.illegal_opcode_reset = illegal_opcode_i;
    cause.illegal_address_reset = illegal_address_i;
    cause.wdog = wd_expire && !in_reset;
    if (in_reset) begin
      next_svc = SRWD_SVC_IDLE;
    end else if (req && !mapped) begin
      cause.illegal_address_reset = 1'b1;
    end else if (wr && is_reg(wb_adr_i, `SRWD_OFF_RESET_STATUS)) begin
      // status bits are never written from the bus
      if (wval == `SRWD_SVC_FIRST) begin
        if (win_bad) begin
          cause.wdog = 1'b1;
        end else begin
          next_svc = SRWD_SVC_ARMED;
        end
      end else if (wval == `SRWD_SVC_SECOND) begin
        if (win_bad) begin
          cause.wdog = 1'b1;
        end else if (svc == SRWD_SVC_ARMED) begin
          wd_clear = 1'b1;
          next_svc = SRWD_SVC_IDLE;
        end
      end else begin
        // any other value resets at once
        cause.wdog = 1'b1;
      end
    end
    any_cause = (cause != '0) || debug_force_reset_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      svc <= SRWD_SVC_IDLE;
    end else begin
      svc <= next_svc;
    end
  end

  // Status register and reset pulse length
  always_comb begin
    next_status = status;
    next_hold_cnt = in_reset ? hold_cnt - 16'h1 : hold_cnt;
    if (any_cause) begin
      next_hold_cnt = HOLD_LOAD;
      // one bit per cause; debug-forced reset leaves all clear
      // Causes arriving during a pulse add to the record
      next_status = in_reset ? (status | cause) : cause;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= '{por: 1'b1, default: 1'b0};
      hold_cnt <= HOLD_LOAD;
    end else begin
      status <= next_status;
      hold_cnt <= next_hold_cnt;
    end
  end

  // Write-once configuration
  always_comb begin
    next_cfg = cfg;
    next_lock_one = lock_one;
    next_lock_two = lock_two;
    if (in_reset) begin
      // back to the enabled default on every reset
      // 1 kHz source and longest timeout
      next_cfg.tsel = `SRWD_TSEL_RESET;
      next_cfg.clk_sel = `SRWD_CLKSEL_RESET;
      next_cfg.win_en = `SRWD_WINEN_RESET;
      next_lock_one = 1'b0;
      next_lock_two = 1'b0;
    end else if (wr && is_reg(wb_adr_i, `SRWD_OFF_OPTIONS_ONE) && !lock_one) begin
      // select field picks period or off
      if (wb_sel_i[0]) begin
        next_cfg.tsel = wb_dat_i[`SRWD_O1_TSEL_LSB +: 2];
      end
      next_lock_one = 1'b1;
    end else if (wr && is_reg(wb_adr_i, `SRWD_OFF_OPTIONS_TWO) && !lock_two) begin
      // source select, bus clock or 1 kHz
      if (wb_sel_i[0]) begin
        next_cfg.clk_sel = wb_dat_i[`SRWD_O2_CLKSEL];
        next_cfg.win_en = wb_dat_i[`SRWD_O2_WINEN];
      end
      next_lock_two = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= '{clk_sel: `SRWD_CLKSEL_RESET, win_en: `SRWD_WINEN_RESET,
               tsel: `SRWD_TSEL_RESET};
      lock_one <= 1'b0;
      lock_two <= 1'b0;
    end else begin
      cfg <= next_cfg;
      lock_one <= next_lock_one;
      lock_two <= next_lock_two;
    end
  end

  // Bus answer: one cycle after the request is seen
  always_comb begin
    next_ack = req;
    next_dat = 32'h0;
    if (req && !wb_we_i) begin
      if (is_reg(wb_adr_i, `SRWD_OFF_RESET_STATUS)) begin
        next_dat[7:0] = status_word(status);
      end else if (is_reg(wb_adr_i, `SRWD_OFF_OPTIONS_ONE)) begin
        next_dat[`SRWD_O1_TSEL_LSB +: 2] = cfg.tsel;
        next_dat[`SRWD_O1_LOCK] = lock_one;
      end else if (is_reg(wb_adr_i, `SRWD_OFF_OPTIONS_TWO)) begin
        next_dat[`SRWD_O2_CLKSEL] = cfg.clk_sel;
        next_dat[`SRWD_O2_WINEN] = cfg.win_en;
        next_dat[`SRWD_O2_LOCK] = lock_two;
      end else if (is_reg(wb_adr_i, `SRWD_OFF_WDOG_COUNT)) begin
        next_dat[CNT_W-1:0] = wd_count;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // Reset-time conditions for the core and pads
  // Registered so they line up with the reset pulse itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b1;
      stack_ptr_init_o <= `SRWD_SP_RESET;
      imask_set_o <= 1'b1;
      periph_disable_o <= 1'b1;
      pins_hiz_o <= 1'b1;
      pullup_enable_o <= 1'b0;
    end else begin
      sys_reset_o <= any_cause || (next_hold_cnt != 16'h0);
      // stack pointer value and interrupt mask
      stack_ptr_init_o <= `SRWD_SP_RESET;
      imask_set_o <= any_cause || (next_hold_cnt != 16'h0);
      // peripherals off, pins high-impedance inputs, no pull-ups
      periph_disable_o <= any_cause || (next_hold_cnt != 16'h0);
      pins_hiz_o <= any_cause || (next_hold_cnt != 16'h0);
      pullup_enable_o <= 1'b0;
    end
  end

endmodule
